/* verilog/drx_pkg.sv */
// package: register map, field positions and reset values of the receiver control bank
package drx_pkg;
	localparam logic [7:0] OFF_POWER    = 8'h12;
	localparam logic [7:0] OFF_SEP_THR  = 8'h13;
	localparam logic [7:0] OFF_SCAN_POL = 8'h14;
	localparam logic [7:0] OFF_POL_STAT = 8'h15;
	localparam logic [7:0] OFF_SLICER   = 8'h16;
	localparam logic [7:0] OFF_LEAD     = 8'h17;
	localparam logic [7:0] OFF_TRAIL    = 8'h18;
	localparam logic [7:0] OFF_TEST_A   = 8'h19;
	localparam logic [7:0] OFF_TEST_B   = 8'h1A;
	localparam logic [7:0] OFF_GAIN     = 8'h1B;
	localparam logic [7:0] OFF_FMT      = 8'h1C;
	localparam logic [7:0] OFF_KEY_STAT = 8'h1D;
	localparam logic [7:0] OFF_TEST_C   = 8'h1E;
	localparam logic [7:0] OFF_TEST_D   = 8'h1F;
	localparam logic [7:0] OFF_KEYPORT  = 8'h20;
	// field positions
	localparam int B_PWR_NORMAL = 0;
	localparam int B_SCAN_EN    = 2;
	localparam int B_COAST_OVR  = 1;
	localparam int B_HS_OVR     = 0;
	localparam int B_POL_LSB    = 5;
	localparam int B_POL_MSB    = 7;
	localparam int B_SLICE_LSB  = 3;
	localparam int B_SLICE_MSB  = 7;
	localparam int B_FTEST_LSB  = 3;
	localparam int B_FTEST_MSB  = 7;
	localparam int B_CR_FIRST   = 2;
	localparam int B_SAMP_TEST  = 1;
	localparam int B_FMT_444    = 0;
	localparam int B_KEYS       = 6;
	localparam int B_DDC_LSB    = 7;
	localparam int B_KMD_SEL    = 6;
	localparam int B_LOW_BW     = 5;
	localparam int B_KDRIVE     = 4;
	localparam int B_INT_OSC    = 3;
	localparam int B_MASK_VIEW  = 2;
	// reset values
	localparam logic       RST_PWR_NORMAL = 1'b1;
	localparam logic [7:0] RST_SEP_THR    = 8'h20;
	localparam logic [4:0] RST_SLICE_LVL  = 5'h17;
	localparam logic [7:0] RST_EDGES      = 8'h00;
	localparam logic [7:0] RST_TEST       = 8'h00;
	localparam logic [4:0] RST_FTEST      = 5'h00;
	localparam logic       RST_FMT_444    = 1'b1;
	localparam logic [7:0] DDC_ADDR_LO    = 8'h74;
	localparam logic [7:0] DDC_ADDR_HI    = 8'h76;
	localparam logic [7:0] RD_NONE        = 8'h00;
	typedef enum logic [0:0] {
		DRX_PH_FIRST  = 1'b0,
		DRX_PH_SECOND = 1'b1
	} drx_phase_t;
endpackage

/* verilog/drx_fmt_if.sv */
// interface: output format controls from the register bank to the formatter
interface drx_fmt_if;
	logic fmt_444;
	logic cr_first;
	logic mask_view;
	logic scan_en;
	modport ctrl (output fmt_444, output cr_first, output mask_view, output scan_en);
	modport fmt  (input fmt_444, input cr_first, input mask_view, input scan_en);
endinterface

/* verilog/drx_formatter.sv */
// module: pixel output formatter with 4:2:2 packing, mask view in 4:4:4 only and scan chain
module drx_formatter (
	input  wire logic   clk_i,
	input  wire logic   nrst_i,
	drx_fmt_if.fmt      f,
	input  wire logic [23:0] pix_i,
	input  wire logic        pix_valid_i,
	input  wire logic [23:0] mask_i,
	input  wire logic        scan_serial_in_i,
	input  wire logic        scan_shift_clock_i,
	output logic [23:0]      chan_o,
	output logic [2:0]       chan_oe_o,
	output logic             scan_serial_out_o
);
	drx_pkg::drx_phase_t phase_q;
	logic                sclk_prev_q;
	logic [23:0]         sel_d;
	logic [7:0]          chroma;

	// per channel choice between video and mask
	for (genvar c = 0; c < 3; c++) begin : g_ch
		assign sel_d[c*8 +: 8] = f.mask_view ? mask_i[c*8 +: 8] : pix_i[c*8 +: 8];
	end

	// red carries the chroma pair, its order set by cr_first
	always_comb begin
		case (phase_q)
			drx_pkg::DRX_PH_FIRST:  chroma = f.cr_first ? pix_i[23:16] : pix_i[7:0];
			drx_pkg::DRX_PH_SECOND: chroma = f.cr_first ? pix_i[7:0] : pix_i[23:16];
			default:                chroma = pix_i[23:16];
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			phase_q <= drx_pkg::DRX_PH_FIRST;
		end else if (f.fmt_444) begin
			phase_q <= drx_pkg::DRX_PH_FIRST;
		end else if (pix_valid_i) begin
			phase_q <= (phase_q == drx_pkg::DRX_PH_FIRST) ? drx_pkg::DRX_PH_SECOND
			                                               : drx_pkg::DRX_PH_FIRST;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= scan_shift_clock_i;
		end
	end

	// scan shifting takes over the output word; video is frozen meanwhile
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			chan_o            <= 24'h000000;
			scan_serial_out_o <= 1'b0;
		end else if (f.scan_en) begin
			if (scan_shift_clock_i && !sclk_prev_q) begin
				chan_o            <= {chan_o[22:0], scan_serial_in_i};
				scan_serial_out_o <= chan_o[23];
			end
		end else if (pix_valid_i) begin
			if (f.fmt_444) begin
				chan_o <= sel_d;
			end else begin
				chan_o <= {chroma, pix_i[15:8], 8'h00};
			end
		end
	end

	// blue floats in 4:2:2, leaving 16 driven lines
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			chan_oe_o <= 3'b111;
		end else begin
			chan_oe_o <= {2'b11, f.fmt_444};
		end
	end

	a_chroma_order: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(pix_valid_i && !f.fmt_444 && !f.scan_en && phase_q == drx_pkg::DRX_PH_FIRST)
		|=> chan_o[23:16] == ($past(f.cr_first) ? $past(pix_i[23:16]) : $past(pix_i[7:0])))
		else $error("chroma order wrong");
	a_mask_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(pix_valid_i && f.fmt_444 && f.mask_view && !f.scan_en)
		|=> chan_o == $past(mask_i))
		else $error("mask not routed to outputs");
endmodule

/* verilog/drx_ctrl_regs.sv */
// module: control and status register bank of the dual display receiver
module drx_ctrl_regs (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	output logic             reg_rvalid_o,
	input  wire logic        hs_pol_det_i,
	input  wire logic        vs_pol_det_i,
	input  wire logic        coast_pol_det_i,
	input  wire logic        keys_loaded_i,
	input  wire logic [1:0]  activity_raw_i,
	output logic [1:0]       activity_o,
	output logic             full_power_down_n_o,
	output logic [7:0]       sep_threshold_o,
	output logic             scan_en_o,
	output logic             coast_pol_user_o,
	output logic             hs_pol_user_o,
	output logic [4:0]       slicer_level_o,
	output logic [7:0]       coast_lead_o,
	output logic [7:0]       coast_trail_o,
	output logic             low_bandwidth_o,
	output logic             internal_osc_o,
	output logic [7:0]       ddc_address_o,
	input  wire logic        key_memory_data_i,
	input  wire logic        key_memory_data_en_i,
	input  wire logic        key_memory_clock_i,
	input  wire logic        control_output_three_i,
	output logic             shared_pin_o,
	output logic             shared_pin_oe_o,
	output logic             key_memory_clock_o,
	output logic             key_memory_clock_oe_o,
	input  wire logic [23:0] pix_i,
	input  wire logic        pix_valid_i,
	input  wire logic [23:0] mask_i,
	input  wire logic        scan_serial_in_i,
	input  wire logic        scan_shift_clock_i,
	output logic [23:0]      chan_o,
	output logic [2:0]       chan_oe_o,
	output logic             scan_serial_out_o
);
	logic       pwr_normal_q;
	logic [7:0] sep_thr_q;
	logic       scan_en_q;
	logic       coast_ovr_q;
	logic       hs_ovr_q;
	logic [2:0] pol_stat_q;
	logic [4:0] slice_lvl_q;
	logic [7:0] lead_q;
	logic [7:0] trail_q;
	logic [7:0] test_a_q;
	logic [7:0] test_b_q;
	logic [7:0] gain_q;
	logic [4:0] ftest_q;
	logic       cr_first_q;
	logic       samp_test_q;
	logic       fmt_444_q;
	logic       keys_q;
	logic [7:0] test_c_q;
	logic [7:0] test_d_q;
	logic       ddc_lsb_q;
	logic       kmd_sel_q;
	logic       low_bw_q;
	logic       kdrive_q;
	logic       int_osc_q;
	logic       mask_view_q;
	logic [1:0] act_q;
	logic [7:0] ddc_addr_q;
	logic       spin_q;
	logic       spin_oe_q;
	logic       kclk_q;
	logic       kclk_oe_q;
	logic [7:0] rdata_q;
	logic       rvalid_q;
	logic [7:0] rd_d;

	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
		return wr && (a == off);
	endfunction

	// every writable field loads its default under reset
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pwr_normal_q <= drx_pkg::RST_PWR_NORMAL;
			sep_thr_q    <= drx_pkg::RST_SEP_THR;
		end else begin
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_POWER)) begin
				pwr_normal_q <= reg_wdata_i[drx_pkg::B_PWR_NORMAL];
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_SEP_THR)) begin
				sep_thr_q <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			scan_en_q   <= 1'b0;
			coast_ovr_q <= 1'b0;
			hs_ovr_q    <= 1'b0;
			slice_lvl_q <= drx_pkg::RST_SLICE_LVL;
			lead_q      <= drx_pkg::RST_EDGES;
			trail_q     <= drx_pkg::RST_EDGES;
		end else begin
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_SCAN_POL)) begin
				scan_en_q   <= reg_wdata_i[drx_pkg::B_SCAN_EN];
				coast_ovr_q <= reg_wdata_i[drx_pkg::B_COAST_OVR];
				hs_ovr_q    <= reg_wdata_i[drx_pkg::B_HS_OVR];
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_SLICER)) begin
				slice_lvl_q <= reg_wdata_i[drx_pkg::B_SLICE_MSB:drx_pkg::B_SLICE_LSB];
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_LEAD)) begin
				lead_q <= reg_wdata_i;
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_TRAIL)) begin
				trail_q <= reg_wdata_i;
			end
		end
	end

	// test bytes are plain storage; their fixed values are software's job
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			test_a_q <= drx_pkg::RST_TEST;
			test_b_q <= drx_pkg::RST_TEST;
			gain_q   <= drx_pkg::RST_TEST;
			test_c_q <= drx_pkg::RST_TEST;
			test_d_q <= drx_pkg::RST_TEST;
		end else begin
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_TEST_A)) begin
				test_a_q <= reg_wdata_i;
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_TEST_B)) begin
				test_b_q <= reg_wdata_i;
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_GAIN)) begin
				gain_q <= reg_wdata_i;
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_TEST_C)) begin
				test_c_q <= reg_wdata_i;
			end
			if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_TEST_D)) begin
				test_d_q <= reg_wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ftest_q     <= drx_pkg::RST_FTEST;
			cr_first_q  <= 1'b0;
			samp_test_q <= 1'b0;
			fmt_444_q   <= drx_pkg::RST_FMT_444;
		end else if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_FMT)) begin
			ftest_q     <= reg_wdata_i[drx_pkg::B_FTEST_MSB:drx_pkg::B_FTEST_LSB];
			cr_first_q  <= reg_wdata_i[drx_pkg::B_CR_FIRST];
			samp_test_q <= reg_wdata_i[drx_pkg::B_SAMP_TEST];
			fmt_444_q   <= reg_wdata_i[drx_pkg::B_FMT_444];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ddc_lsb_q   <= 1'b0;
			kmd_sel_q   <= 1'b0;
			low_bw_q    <= 1'b0;
			kdrive_q    <= 1'b0;
			int_osc_q   <= 1'b0;
			mask_view_q <= 1'b0;
		end else if (wr_hit(reg_wr_i, reg_addr_i, drx_pkg::OFF_KEYPORT)) begin
			ddc_lsb_q   <= reg_wdata_i[drx_pkg::B_DDC_LSB];
			kmd_sel_q   <= reg_wdata_i[drx_pkg::B_KMD_SEL];
			low_bw_q    <= reg_wdata_i[drx_pkg::B_LOW_BW];
			kdrive_q    <= reg_wdata_i[drx_pkg::B_KDRIVE];
			int_osc_q   <= reg_wdata_i[drx_pkg::B_INT_OSC];
			mask_view_q <= reg_wdata_i[drx_pkg::B_MASK_VIEW];
		end
	end

	// status follows the detectors only; bus writes never reach it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pol_stat_q <= 3'h0;
			keys_q     <= 1'b0;
		end else begin
			pol_stat_q <= {hs_pol_det_i, vs_pol_det_i, coast_pol_det_i};
			keys_q     <= keys_loaded_i;
		end
	end

	// detectors are dead in power down, so raw activity is not trusted
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			act_q <= 2'b00;
		end else begin
			act_q <= pwr_normal_q ? activity_raw_i : 2'b00;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ddc_addr_q <= drx_pkg::DDC_ADDR_LO;
		end else begin
			ddc_addr_q <= ddc_lsb_q ? drx_pkg::DDC_ADDR_HI : drx_pkg::DDC_ADDR_LO;
		end
	end

	// third control output is always driven; key lines only when enabled
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			spin_q    <= 1'b0;
			spin_oe_q <= 1'b0;
			kclk_q    <= 1'b0;
			kclk_oe_q <= 1'b0;
		end else begin
			spin_q    <= kmd_sel_q ? key_memory_data_i : control_output_three_i;
			spin_oe_q <= kmd_sel_q ? (kdrive_q && key_memory_data_en_i) : 1'b1;
			kclk_q    <= key_memory_clock_i;
			kclk_oe_q <= kdrive_q;
		end
	end

	always_comb begin
		case (reg_addr_i)
			drx_pkg::OFF_POWER:    rd_d = {7'h00, pwr_normal_q};
			drx_pkg::OFF_SEP_THR:  rd_d = sep_thr_q;
			drx_pkg::OFF_SCAN_POL: rd_d = {5'h00, scan_en_q, coast_ovr_q, hs_ovr_q};
			drx_pkg::OFF_POL_STAT: rd_d = {pol_stat_q, 5'h00};
			drx_pkg::OFF_SLICER:   rd_d = {slice_lvl_q, 3'h0};
			drx_pkg::OFF_LEAD:     rd_d = lead_q;
			drx_pkg::OFF_TRAIL:    rd_d = trail_q;
			drx_pkg::OFF_TEST_A:   rd_d = test_a_q;
			drx_pkg::OFF_TEST_B:   rd_d = test_b_q;
			drx_pkg::OFF_GAIN:     rd_d = gain_q;
			drx_pkg::OFF_FMT:      rd_d = {ftest_q, cr_first_q, samp_test_q, fmt_444_q};
			drx_pkg::OFF_KEY_STAT: rd_d = {1'b0, keys_q, 6'h00};
			drx_pkg::OFF_TEST_C:   rd_d = test_c_q;
			drx_pkg::OFF_TEST_D:   rd_d = test_d_q;
			drx_pkg::OFF_KEYPORT:  rd_d = {ddc_lsb_q, kmd_sel_q, low_bw_q, kdrive_q,
			                              int_osc_q, mask_view_q, 2'b00};
			default:               rd_d = drx_pkg::RD_NONE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_q  <= drx_pkg::RD_NONE;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_i;
			if (reg_rd_i) begin
				rdata_q <= rd_d;
			end
		end
	end
	drx_fmt_if fmt_bus ();
	assign fmt_bus.fmt_444   = fmt_444_q;
	assign fmt_bus.cr_first  = cr_first_q;
	assign fmt_bus.mask_view = mask_view_q;
	assign fmt_bus.scan_en   = scan_en_q;
	drx_formatter u_fmt (
		.clk_i              (clk_i),
		.nrst_i             (nrst_i),
		.f                  (fmt_bus),
		.pix_i              (pix_i),
		.pix_valid_i        (pix_valid_i),
		.mask_i             (mask_i),
		.scan_serial_in_i   (scan_serial_in_i),
		.scan_shift_clock_i (scan_shift_clock_i),
		.chan_o             (chan_o),
		.chan_oe_o          (chan_oe_o),
		.scan_serial_out_o  (scan_serial_out_o)
	);
	assign reg_rdata_o           = rdata_q;
	assign reg_rvalid_o          = rvalid_q;
	assign activity_o            = act_q;
	assign full_power_down_n_o   = pwr_normal_q;
	assign sep_threshold_o       = sep_thr_q;
	assign scan_en_o             = scan_en_q;
	assign coast_pol_user_o      = coast_ovr_q;
	assign hs_pol_user_o         = hs_ovr_q;
	assign slicer_level_o        = slice_lvl_q;
	assign coast_lead_o          = lead_q;
	assign coast_trail_o         = trail_q;
	assign low_bandwidth_o       = low_bw_q;
	assign internal_osc_o        = int_osc_q;
	assign ddc_address_o         = ddc_addr_q;
	assign shared_pin_o          = spin_q;
	assign shared_pin_oe_o       = spin_oe_q;
	assign key_memory_clock_o    = kclk_q;
	assign key_memory_clock_oe_o = kclk_oe_q;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_power_bit: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_POWER
		|=> full_power_down_n_o == $past(reg_wdata_i[drx_pkg::B_PWR_NORMAL]))
		else $error("power bit not loaded");
	a_activity_gated: assert property (
		!full_power_down_n_o |=> activity_o == 2'b00)
		else $error("activity reported in power down");
	a_sep_threshold: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_SEP_THR |=> sep_threshold_o == $past(reg_wdata_i))
		else $error("separator threshold not loaded");
	a_scan_pol_bits: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_SCAN_POL
		|=> {scan_en_o, coast_pol_user_o, hs_pol_user_o} == $past(reg_wdata_i[2:0]))
		else $error("scan or polarity override not loaded");
	a_pol_status_rd: assert property (
		reg_rd_i && reg_addr_i == drx_pkg::OFF_POL_STAT
		|=> reg_rvalid_o && reg_rdata_o == {$past(pol_stat_q), 5'h00})
		else $error("polarity status read wrong");
	a_slicer_level: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_SLICER |=> slicer_level_o == $past(reg_wdata_i[7:3]))
		else $error("slicer level not loaded");
	a_lead_edges: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_LEAD |=> coast_lead_o == $past(reg_wdata_i))
		else $error("lead edge count not loaded");
	a_trail_edges: assert property (
		reg_wr_i && reg_addr_i == drx_pkg::OFF_TRAIL |=> coast_trail_o == $past(reg_wdata_i))
		else $error("trail edge count not loaded");
	a_keys_status: assert property (
		keys_loaded_i ##1 (reg_rd_i && reg_addr_i == drx_pkg::OFF_KEY_STAT && keys_loaded_i)
		|=> reg_rdata_o == 8'h40)
		else $error("key status read wrong");
	a_ddc_address: assert property (
		ddc_lsb_q ##1 ddc_lsb_q |-> ddc_address_o == drx_pkg::DDC_ADDR_HI)
		else $error("key channel address wrong");
	a_shared_pin_ctl: assert property (
		!kmd_sel_q |=> shared_pin_oe_o && shared_pin_o == $past(control_output_three_i))
		else $error("shared pin not third control");
	a_key_float: assert property (
		!kdrive_q |=> !key_memory_clock_oe_o && (!shared_pin_oe_o || !$past(kmd_sel_q)))
		else $error("key lines driven while floated");
	a_blue_float: assert property (
		!fmt_444_q |=> chan_oe_o == 3'b110)
		else $error("blue driven in 4:2:2");
	c_power_down: cover property (!full_power_down_n_o ##1 full_power_down_n_o);
	c_fmt_422: cover property (!fmt_444_q && pix_valid_i ##1 pix_valid_i);
	c_scan_shift: cover property (scan_en_o && scan_shift_clock_i ##1 !scan_shift_clock_i);
endmodule

/* tb/tb_top.sv */
// testbench: self-checking run of the receiver control register bank
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, thr, lead, trail, ddc;
	logic        wr = 1'b0, rd = 1'b0, rvalid, keys = 1'b0;
	logic [2:0]  det = 3'h0, oe;
	logic [1:0]  act_raw = 2'h0, act;
	logic        pwr_n, scan_en, coast_usr, hs_usr, low_bw, int_osc, sp, sp_oe, kco, kco_oe;
	logic [4:0]  slc;
	logic        kd = 1'b0, kd_en = 1'b0, kc = 1'b0, ctl_three = 1'b0;
	logic [23:0] pix = 24'h000000, mask = 24'h000000, chan, p;
	logic        pv = 1'b0, sin = 1'b0, sclk = 1'b0, sout;
	logic [7:0]  rexp_q[$];
	logic [7:0]  sh [0:255];
	logic [31:0] rnd = 32'd45137;
	int          err_count = 0, total_checks = 0, cycles = 0;

	drx_ctrl_regs drx_ctrl_regs_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .hs_pol_det_i(det[2]), .vs_pol_det_i(det[1]),
		.coast_pol_det_i(det[0]), .keys_loaded_i(keys), .activity_raw_i(act_raw),
		.activity_o(act), .full_power_down_n_o(pwr_n), .sep_threshold_o(thr),
		.scan_en_o(scan_en), .coast_pol_user_o(coast_usr), .hs_pol_user_o(hs_usr),
		.slicer_level_o(slc), .coast_lead_o(lead), .coast_trail_o(trail),
		.low_bandwidth_o(low_bw), .internal_osc_o(int_osc), .ddc_address_o(ddc),
		.key_memory_data_i(kd), .key_memory_data_en_i(kd_en), .key_memory_clock_i(kc),
		.control_output_three_i(ctl_three), .shared_pin_o(sp), .shared_pin_oe_o(sp_oe),
		.key_memory_clock_o(kco), .key_memory_clock_oe_o(kco_oe), .pix_i(pix),
		.pix_valid_i(pv), .mask_i(mask), .scan_serial_in_i(sin),
		.scan_shift_clock_i(sclk), .chan_o(chan), .chan_oe_o(oe),
		.scan_serial_out_o(sout));

	always #5 clk_i = ~clk_i;

	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction

	// writable bits of each offset; status and unmapped places take nothing
	function automatic logic [7:0] msk(input logic [7:0] a);
		case (a)
			8'h12: return 8'h01;
			8'h14: return 8'h07;
			8'h16: return 8'hF8;
			8'h20: return 8'hFC;
			8'h13, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E, 8'h1F: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		if (a == 8'h15) return {det, 5'h00};
		if (a == 8'h1D) return {1'b0, keys, 6'h00};
		return sh[a];
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr = a;
		wdata = d;
		wr = 1'b1;
		sh[a] = d & msk(a);
		@(negedge clk_i);
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(negedge clk_i);
		addr = a;
		rd = 1'b1;
		rexp_q.push_back(exp_rd(a));
		@(negedge clk_i);
		rd = 1'b0;
	endtask

	task automatic pixel(input logic [23:0] v);
		@(negedge clk_i);
		pix = v;
		pv = 1'b1;
		@(negedge clk_i);
		pv = 1'b0;
	endtask

	// read data is matched against the oldest note taken when the read was issued
	always @(negedge clk_i) begin
		if (rvalid === 1'b1) begin
			if (rexp_q.size() == 0)
				check("unrequested rdata", 32'd1, 32'd0);
			else
				check("rdata", rdata, rexp_q.pop_front());
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			end_of_test();
		end
	end

	initial begin
		foreach (sh[i]) sh[i] = 8'h00;
		sh[8'h12] = 8'h01;
		sh[8'h13] = 8'h20;
		sh[8'h16] = 8'hB8;
		sh[8'h1C] = 8'h01;
		det = 3'(xs());
		keys = 1'b1;
		repeat (6) @(negedge clk_i);
		nrst_i = 1'b1;
		for (int a = 'h11; a <= 'h21; a++) rd_reg(8'(a));
		check("power", pwr_n, 1);
		check("threshold", thr, 32);
		check("slicer", slc, 23);
		check("lead trail", {lead, trail}, 0);
		check("scan pol", {scan_en, coast_usr, hs_usr, low_bw, int_osc}, 0);
		check("ddc", ddc, 8'h74);
		check("chan oe", oe, 3'h7);
		check("key clk oe", kco_oe, 0);
		// fixed test values honoured; 0x19 left alone
		for (int a = 'h12; a <= 'h20; a++) begin
			case (a)
				'h19: ;
				'h13: wr_reg(8'h13, 8'h80 | 8'(xs()));
				'h1A: wr_reg(8'h1A, 8'h41);
				'h1B: wr_reg(8'h1B, 8'h00);
				'h1C: wr_reg(8'h1C, 8'(xs() & 32'h05));
				'h1E: wr_reg(8'h1E, 8'hFF);
				'h1F: wr_reg(8'h1F, 8'h84);
				default: wr_reg(8'(a), 8'(xs()));
			endcase
		end
		det = 3'(xs());
		keys = 1'b0;
		for (int a = 'h11; a <= 'h21; a++) rd_reg(8'(a));
		check("threshold", thr, sh[8'h13]);
		check("slicer", slc, sh[8'h16][7:3]);
		check("lead", lead, sh[8'h17]);
		check("trail", trail, sh[8'h18]);
		check("scan pol", {scan_en, coast_usr, hs_usr}, sh[8'h14][2:0]);
		check("bw osc", {low_bw, int_osc}, {sh[8'h20][5], sh[8'h20][3]});
		// shared pin, key lines and port address over all select combinations
		for (int i = 0; i < 8; i++) begin
			{kd, kc, ctl_three} = 3'(xs());
			kd_en = 1'b1;
			wr_reg(8'h20, {i[2], i[1], 1'b0, i[0], 4'h0});
			@(negedge clk_i);
			check("ddc", ddc, i[2] ? 8'h76 : 8'h74);
			check("pin oe", sp_oe, i[1] ? i[0] : 1'b1);
			if (sp_oe === 1'b1) check("pin", sp, i[1] ? kd : ctl_three);
			check("key clk oe", kco_oe, i[0]);
			check("key clk", kco, kc);
		end
		act_raw = 2'h3;
		wr_reg(8'h12, 8'h00);
		repeat (2) @(negedge clk_i);
		check("powered down", {pwr_n, act}, 3'h0);
		wr_reg(8'h12, 8'h01);
		repeat (2) @(negedge clk_i);
		check("activity", act, 2'h3);
		wr_reg(8'h14, 8'h00);
		for (int cr = 1; cr >= 0; cr--) begin
			wr_reg(8'h1C, 8'h01);
			wr_reg(8'h1C, {5'h00, 1'(cr), 2'h0});
			@(negedge clk_i);
			check("oe 422", oe, 3'h6);
			p = 24'(xs());
			pixel(p);
			check("chroma a", chan, {cr ? p[23:16] : p[7:0], p[15:8], 8'h00});
			p = 24'(xs());
			pixel(p);
			check("chroma b", chan, {cr ? p[7:0] : p[23:16], p[15:8], 8'h00});
		end
		wr_reg(8'h1C, 8'h01);
		wr_reg(8'h20, 8'h04);
		mask = 24'(xs());
		pixel(24'(xs()));
		check("mask view", chan, mask);
		wr_reg(8'h20, 8'h00);
		p = 24'(xs());
		pixel(p);
		check("pix 444", chan, p);
		wr_reg(8'h14, 8'h04);
		sin = 1'b1;
		@(negedge clk_i);
		sclk = 1'b1;
		@(negedge clk_i);
		sclk = 1'b0;
		check("scan chain", {sout, chan}, {p, 1'b1});
		pixel(~p);
		check("scan hold", chan, {p[22:0], 1'b1});
		// mid-run reset must bring power, threshold, slicer, scan enable, port address and outputs back to their defaults
		nrst_i = 1'b0;
		repeat (2) @(negedge clk_i);
		nrst_i = 1'b1;
		check("reset fields", {pwr_n, thr, slc, scan_en, ddc}, {1'b1, 8'h20, 5'h17, 1'b0, 8'h74});
		check("reset outputs", {chan, oe}, {24'h000000, 3'h7});
		repeat (3) @(negedge clk_i);
		check("reads left", rexp_q.size(), 0);
		end_of_test();
	end
endmodule
